// file: src/oss_top.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
// Notes on behaviour
// R01: Configuration PLL force keeps the 4x PLL on, ignoring the software bit.
// R02: Without force, control bit 7 turns the 4x PLL on or off.
// R03: Frequency codes 1111/1101/1100/1011 give 16/4/2/1 MHz from HF.
// R04: Code 1110 gives 8 MHz, or 32 MHz with the software PLL bit.
// R05: Codes 1010-1000 divide HF; 0111-0100 divide MF; 0111 at reset.
// R06: 0011 is HF 31.25 kHz, 0010 MF 31.25 kHz, 000x the LF oscillator.
// R07: Select 1x internal, 01 secondary, 00 configuration-word source.
// R08: Control bit 2 always reads zero.
// R09: With secondary enabled, status bit 7 follows secondary readiness.
// R10: With secondary disabled, status bit 7 reads one.
// R11: Status bit 6 shows PLL ready.
// R12: Status bit 5 is one while running from the configuration-word source.
// R13: Status bits 4, 2, 1 show HF, MF, LF oscillator ready.
// R14: Status bit 3 shows HF locked within 2 percent.
// R15: Status bit 0 shows HF stable within 0.5 percent.
// R16: Six-bit signed trim: zero calibrated, 011111 max, 100000 min.
// R17: On external clock failure switch to internal and set the fail flag.
// R18: Changing the select restarts the start-up timer; internal runs meanwhile.
// R19: Crystal sources wait 1024 oscillations before use.
// R20: Analog ready and accuracy inputs are synchronised before use.
module oss_top
  import oss_pkg::*;
#(
  parameter int OST_COUNT = OSS_OST_COUNT
)
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration words and peripheral settings
  input wire logic cfg_pll_force,
  input wire logic [2:0] cfg_clock_source,
  input wire logic cfg_fail_monitor_en,
  input wire logic secondary_osc_enable,
  // Analog oscillator indications
  input wire logic secondary_osc_ready_raw,
  input wire logic pll_ready_raw,
  input wire logic high_freq_ready_raw,
  input wire logic high_freq_locked_raw,
  input wire logic mid_freq_ready_raw,
  input wire logic low_freq_ready_raw,
  input wire logic high_freq_stable_raw,
  input wire logic ext_clk_fail_raw,
  input wire logic ext_osc_toggle,
  // Clock steering outputs
  output logic pll_enable,
  output logic [1:0] clk_source,
  output logic [1:0] internal_osc,
  output logic [3:0] internal_div_log2,
  output logic [5:0] freq_trim,
  output logic startup_timer_status,
  output logic osc_fail_flag
);

  // ==========================================================================
  // Frequency decode: oscillator and power-of-two divider for a select code.
  function automatic logic [5:0] oss_freq_decode(input logic [3:0] code);
    logic [5:0] r;
    r = {OSS_OSC_LF, 4'h0}; // R06
    case (code)
      4'hF: r = {OSS_OSC_HF, 4'h0}; // R03
      4'hE: r = {OSS_OSC_HF, 4'h1}; // R04
      4'hD: r = {OSS_OSC_HF, 4'h2}; // R03
      4'hC: r = {OSS_OSC_HF, 4'h3};
      4'hB: r = {OSS_OSC_HF, 4'h4};
      4'hA: r = {OSS_OSC_HF, 4'h5}; // R05
      4'h9: r = {OSS_OSC_HF, 4'h6};
      4'h8: r = {OSS_OSC_HF, 4'h7};
      4'h7: r = {OSS_OSC_MF, 4'h0};
      4'h6: r = {OSS_OSC_MF, 4'h1};
      4'h5: r = {OSS_OSC_MF, 4'h2};
      4'h4: r = {OSS_OSC_MF, 4'h3};
      4'h3: r = {OSS_OSC_HF, 4'h9}; // R06
      4'h2: r = {OSS_OSC_MF, 4'h4};
      default: r = {OSS_OSC_LF, 4'h0};
    endcase
    return r;
  endfunction : oss_freq_decode

  // ==========================================================================
  // Synchronised analog indications.
  // Every analog level passes two flip-flops before any decision reads it.
  logic [8:0] raw_in;
  logic [8:0] syn;
  assign raw_in = {ext_osc_toggle, ext_clk_fail_raw, secondary_osc_ready_raw, pll_ready_raw,
                   high_freq_ready_raw, high_freq_locked_raw, mid_freq_ready_raw,
                   low_freq_ready_raw, high_freq_stable_raw};

  oss_sync #(.WIDTH(9)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(raw_in), // R20
    .sync_out(syn)
  );

  // ==========================================================================
  // Registers.
  logic soft_pll_on_r;
  logic [3:0] internal_freq_sel_r;
  logic [1:0] sys_clk_sel_r;
  logic [5:0] freq_trim_r;
  logic osc_fail_flag_r;
  logic osc_fail_irq_enable_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic pll_enable_r;
  logic [1:0] clk_source_r;
  logic [1:0] internal_osc_r;
  logic [3:0] internal_div_r;
  logic startup_status_r;

  // ==========================================================================
  // APB decode: one wait state, write committed at the edge with pready high.
  logic access;
  logic commit;
  logic hit_ctl;
  logic hit_sta;
  logic hit_tun;
  logic hit_fail;
  logic mapped;
  logic wr_ctl;
  logic wr_tun;
  logic wr_fail;
  logic sel_change;
  logic [7:0] ctl_val;
  logic [7:0] sta_val;
  logic [7:0] tun_val;
  logic [7:0] fail_val;
  logic [7:0] rd_val;
  logic [31:0] prdata_nxt;
  logic slverr_nxt;

  assign access = psel && penable && !pready_r;
  assign commit = psel && penable && pready_r;
  assign hit_ctl = (paddr == OSS_ADDR_CONTROL);
  assign hit_sta = (paddr == OSS_ADDR_STATUS);
  assign hit_tun = (paddr == OSS_ADDR_TUNING);
  assign hit_fail = (paddr == OSS_ADDR_FAIL);
  assign mapped = hit_ctl || hit_sta || hit_tun || hit_fail;
  assign wr_ctl = commit && pwrite && hit_ctl;
  assign wr_tun = commit && pwrite && hit_tun;
  assign wr_fail = commit && pwrite && hit_fail;
  // Rewriting the select with its present value leaves the timer and failure state alone.
  assign sel_change = wr_ctl && (pwdata[OSS_CTL_SEL_HI:OSS_CTL_SEL_LO] != sys_clk_sel_r);

  // ==========================================================================
  // Start-up timer and fail monitor.
  oss_st_if st ();
  assign st.restart = sel_change; // R18
  assign st.crystal = (cfg_clock_source == OSS_CFG_LP) || (cfg_clock_source == OSS_CFG_XT) ||
                      (cfg_clock_source == OSS_CFG_HS);
  assign st.monitor_en = cfg_fail_monitor_en;
  assign st.ext_fail = syn[7];
  assign st.ext_tick = syn[8];

  oss_startup #(.OST_COUNT(OST_COUNT)) u_startup (
    .pclk(pclk),
    .presetn(presetn),
    .st(st)
  );

  // ==========================================================================
  // Clock steering.
  logic [5:0] dec;
  logic run_cfg;
  logic pll_on;
  logic [1:0] src_nxt;
  logic pll_32m;
  logic [3:0] div_nxt;

  assign dec = oss_freq_decode(internal_freq_sel_r);
  assign pll_on = cfg_pll_force || soft_pll_on_r; // R01 R02
  // Config source is used only after the timer and while no failure stands.
  assign run_cfg = (sys_clk_sel_r == OSS_SEL_CONFIG) && st.timer_done && !st.failed &&
                   (cfg_clock_source != OSS_CFG_INTERNAL); // R12 R17 R18
  assign src_nxt = sys_clk_sel_r[1] ? OSS_SRC_INTERNAL :
                   (sys_clk_sel_r == OSS_SEL_SECONDARY) ? OSS_SRC_SECONDARY :
                   run_cfg ? OSS_SRC_CONFIG : OSS_SRC_INTERNAL; // R07
  // With the software PLL bit, code 1110 runs the 8 MHz tap through the 4x PLL, so no division is left.
  assign pll_32m = (internal_freq_sel_r == 4'hE) && soft_pll_on_r;
  assign div_nxt = pll_32m ? 4'h0 : dec[3:0]; // R04

  // ==========================================================================
  // Read values.
  assign ctl_val = {soft_pll_on_r, internal_freq_sel_r, 1'b0, sys_clk_sel_r}; // R08
  assign sta_val = {secondary_osc_enable ? syn[6] : 1'b1, // R09 R10
                    syn[5], // R11
                    startup_status_r, // R12
                    syn[4], syn[3], syn[2], syn[1], syn[0]}; // R13 R14 R15
  assign tun_val = {2'h0, freq_trim_r};
  assign fail_val = {6'h00, osc_fail_irq_enable_r, osc_fail_flag_r};
  assign rd_val = hit_ctl ? ctl_val : hit_sta ? sta_val : hit_tun ? tun_val :
                  hit_fail ? fail_val : 8'h00;
  // Read data stands only in the answer cycle; it is zero at all other times.
  assign prdata_nxt = (access && !pwrite) ? {24'h000000, rd_val} : 32'h00000000;
  assign slverr_nxt = access && !mapped;

  // Bus answer: pready, pslverr and prdata are registered one-cycle pulses.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= access;
      pslverr_r <= slverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // The control word is loaded whole on the edge at which the write commits.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      soft_pll_on_r <= 1'b0;
      internal_freq_sel_r <= OSS_FREQ_RESET; // R05
      sys_clk_sel_r <= OSS_SEL_RESET;
    end
    else if (wr_ctl)
    begin
      soft_pll_on_r <= pwdata[OSS_CTL_PLL_BIT];
      internal_freq_sel_r <= pwdata[OSS_CTL_FREQ_HI:OSS_CTL_FREQ_LO];
      sys_clk_sel_r <= pwdata[OSS_CTL_SEL_HI:OSS_CTL_SEL_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_trim_r <= OSS_TRIM_RESET;
      osc_fail_irq_enable_r <= 1'b0;
    end
    else
    begin
      if (wr_tun)
        freq_trim_r <= pwdata[5:0]; // R16
      if (wr_fail)
        osc_fail_irq_enable_r <= pwdata[OSS_FAIL_IE_BIT];
    end
  end

  // Fail flag: a new failure wins over a write-one-to-clear in the same cycle.
  logic fail_clear;
  logic fail_flag_nxt;
  assign fail_clear = wr_fail && pwdata[OSS_FAIL_FLAG_BIT];
  assign fail_flag_nxt = st.fail_event || (osc_fail_flag_r && !fail_clear); // R17

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_fail_flag_r <= 1'b0;
    else
      osc_fail_flag_r <= fail_flag_nxt; // R17
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pll_enable_r <= 1'b0;
      clk_source_r <= OSS_SRC_INTERNAL;
      internal_osc_r <= OSS_OSC_MF;
      internal_div_r <= 4'h0;
      startup_status_r <= 1'b0;
    end
    else
    begin
      pll_enable_r <= pll_on; // R01 R02
      clk_source_r <= src_nxt; // R07 R17
      internal_osc_r <= dec[5:4]; // R03 R05 R06
      internal_div_r <= div_nxt; // R04
      startup_status_r <= run_cfg; // R12
    end
  end

  // ==========================================================================
  // Outputs.
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pll_enable = pll_enable_r;
  assign clk_source = clk_source_r;
  assign internal_osc = internal_osc_r;
  assign internal_div_log2 = internal_div_r;
  assign freq_trim = freq_trim_r; // R16
  assign startup_timer_status = startup_status_r;
  assign osc_fail_flag = osc_fail_flag_r;

endmodule : oss_top

// file: src/oss_pkg.sv
package oss_pkg;

  // ==========================================================================
  // Register map (byte addresses on the APB bus).
  localparam logic [11:0] OSS_ADDR_CONTROL = 12'h000;
  localparam logic [11:0] OSS_ADDR_STATUS = 12'h004;
  localparam logic [11:0] OSS_ADDR_TUNING = 12'h008;
  localparam logic [11:0] OSS_ADDR_FAIL = 12'h00C;

  // ==========================================================================
  // Control register fields and reset values, and the tuning register reset value.
  localparam int OSS_CTL_PLL_BIT = 7;
  localparam int OSS_CTL_FREQ_HI = 6;
  localparam int OSS_CTL_FREQ_LO = 3;
  localparam int OSS_CTL_SEL_HI = 1;
  localparam int OSS_CTL_SEL_LO = 0;
  localparam logic [3:0] OSS_FREQ_RESET = 4'h7;
  localparam logic [1:0] OSS_SEL_RESET = 2'h0;
  localparam logic [5:0] OSS_TRIM_RESET = 6'h00;

  // Fail register fields.
  localparam int OSS_FAIL_FLAG_BIT = 0;
  localparam int OSS_FAIL_IE_BIT = 1;

  // ==========================================================================
  // System clock select codes.
  localparam logic [1:0] OSS_SEL_CONFIG = 2'h0;
  localparam logic [1:0] OSS_SEL_SECONDARY = 2'h1;

  // Configuration-word source codes.
  localparam logic [2:0] OSS_CFG_LP = 3'h0;
  localparam logic [2:0] OSS_CFG_XT = 3'h1;
  localparam logic [2:0] OSS_CFG_HS = 3'h2;
  localparam logic [2:0] OSS_CFG_INTERNAL = 3'h4;

  // Start-up timer oscillation count.
  localparam int OSS_OST_COUNT = 1024;

  // ==========================================================================
  // Oscillator and clock source choices.
  typedef enum logic [1:0] {OSS_OSC_HF, OSS_OSC_MF, OSS_OSC_LF} oss_osc_t;
  typedef enum logic [1:0] {OSS_SRC_INTERNAL, OSS_SRC_SECONDARY, OSS_SRC_CONFIG} oss_src_t;

endpackage : oss_pkg

// file: src/oss_st_if.sv
`timescale 1ns/100ps
interface oss_st_if;
  logic restart;
  logic crystal;
  logic monitor_en;
  logic ext_fail;
  logic ext_tick;
  logic timer_done;
  logic fail_event;
  logic failed;

  modport ctrl (output restart, output crystal, output monitor_en, output ext_fail, output ext_tick,
                input timer_done, input fail_event, input failed);
  modport timer (input restart, input crystal, input monitor_en, input ext_fail, input ext_tick,
                 output timer_done, output fail_event, output failed);
endinterface : oss_st_if

// file: src/oss_sync.sv
`timescale 1ns/100ps
module oss_sync
  import oss_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // ==========================================================================
  // Two-flop synchroniser per bit.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta_r[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_r[i] <= async_in[i];
          sync_out[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule : oss_sync

// file: src/oss_startup.sv
`timescale 1ns/100ps
module oss_startup
  import oss_pkg::*;
#(
  parameter int OST_COUNT = OSS_OST_COUNT
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to the control logic
  oss_st_if.timer st
);

  localparam int CW = $clog2(OST_COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(OST_COUNT);

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic failed_r;
  logic tick_d_r;
  logic tick_edge;
  logic counted;
  logic fail_hit;

  // ==========================================================================
  // Oscillation counting; non-crystal sources need no settling time.
  assign tick_edge = st.ext_tick & ~tick_d_r;
  assign counted = (count_r == LAST);
  assign count_nxt = st.restart ? '0 : (tick_edge && !counted) ? count_r + CW'(1) : count_r;
  assign st.timer_done = !st.crystal || counted; // R19
  // The monitor only watches once the timer has expired.
  assign fail_hit = st.monitor_en && st.timer_done && st.ext_fail && !failed_r;
  assign st.fail_event = fail_hit;
  assign st.failed = failed_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_r <= '0;
      tick_d_r <= 1'b0;
      failed_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt; // R18 R19
      tick_d_r <= st.ext_tick;
      // A failure seen in the cycle of a restart still wins, as it does for the fail flag.
      failed_r <= fail_hit || (failed_r && !st.restart); // R17 R18
    end
  end

endmodule : oss_startup

// file: tb/oss_top_assertions.sv
`timescale 1ns/100ps
module oss_top_assertions
  import oss_pkg::*;
#(
  parameter int OST_COUNT = OSS_OST_COUNT
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Steering
  input wire logic cfg_pll_force,
  input wire logic pll_enable,
  input wire logic [1:0] clk_source,
  input wire logic [5:0] freq_trim,
  input wire logic startup_timer_status,
  input wire logic osc_fail_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_done = psel && penable && pready && pwrite;
  wire ctl_wr = wr_done && paddr == OSS_ADDR_CONTROL;
  wire tun_wr = wr_done && paddr == OSS_ADDR_TUNING;
  // ==========================================================================
  // Bus handshake.
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready not one cycle after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_answer; pready |-> psel && penable; endproperty
  a_answer: assert property (p_answer) else $error("pready without access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("prdata not zero outside answer");
  // ==========================================================================
  // Clock steering.
  property p_force; cfg_pll_force |=> pll_enable; endproperty
  a_force: assert property (p_force) else $error("pll off under force");
  property p_soft; ctl_wr && !cfg_pll_force ##1 !cfg_pll_force |=> pll_enable == $past(pwdata[7], 2); endproperty
  a_soft: assert property (p_soft) else $error("pll_enable not soft bit");
  property p_intl; ctl_wr && pwdata[1] |=> ##1 clk_source == 2'h0; endproperty
  a_intl: assert property (p_intl) else $error("internal select ignored");
  property p_trim; tun_wr |=> ##1 freq_trim == $past(pwdata[5:0], 2); endproperty
  a_trim: assert property (p_trim) else $error("freq_trim not written value");
  property p_ost; startup_timer_status == (clk_source == 2'h2); endproperty
  a_ost: assert property (p_ost) else $error("timer status and source disagree");
  property p_fail; $rose(osc_fail_flag) |-> ##[0:2] clk_source == 2'h0; endproperty
  a_fail: assert property (p_fail) else $error("no switch to internal on failure");
endmodule : oss_top_assertions

bind oss_top oss_top_assertions #(.OST_COUNT(OST_COUNT)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cfg_pll_force(cfg_pll_force), .pll_enable(pll_enable), .clk_source(clk_source),
  .freq_trim(freq_trim), .startup_timer_status(startup_timer_status), .osc_fail_flag(osc_fail_flag));

// file: tb/tb_oss_top.sv
`timescale 1ns/100ps
module tb_oss_top
  import oss_pkg::*;
;
  localparam int OSTN = 8;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic force_pll = 0;
  logic mon_en = 0;
  logic sec_en = 0;
  logic [2:0] cfg_src = OSS_CFG_INTERNAL;
  logic [6:0] rdy = 0;
  logic fail_raw = 0;
  logic tgl = 0;
  logic [31:0] prdata, r;
  logic pready, pslverr, pll_enable, startup_timer, fail_flag;
  logic [1:0] clk_source, internal_osc;
  logic [3:0] div;
  logic [5:0] freq_trim;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [5:0] tv[4] = '{6'h20, 6'h1F, 6'h00, 6'h3F};
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int i;
  integer seed = 32'hdab0119d;

  oss_top #(.OST_COUNT(OSTN)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_pll_force(force_pll), .cfg_clock_source(cfg_src), .cfg_fail_monitor_en(mon_en),
    .secondary_osc_enable(sec_en), .secondary_osc_ready_raw(rdy[6]), .pll_ready_raw(rdy[5]),
    .high_freq_ready_raw(rdy[4]), .high_freq_locked_raw(rdy[3]), .mid_freq_ready_raw(rdy[2]),
    .low_freq_ready_raw(rdy[1]), .high_freq_stable_raw(rdy[0]), .ext_clk_fail_raw(fail_raw),
    .ext_osc_toggle(tgl), .pll_enable(pll_enable), .clk_source(clk_source), .internal_osc(internal_osc),
    .internal_div_log2(div), .freq_trim(freq_trim), .startup_timer_status(startup_timer), .osc_fail_flag(fail_flag));

  // ==========================================================================
  // Helpers.
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] expv);
    checks_done++;
    if (seen !== expv)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, expv, seen);
    end
  endtask : chk

  task give_verdict;
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Expected answer is {pslverr, prdata}; the monitor compares it.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] ex);
    exp_q.push_back(ex);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic logic [7:0] stat(logic t);
    return {sec_en ? rdy[6] : 1'b1, rdy[5], t, rdy[4:0]};
  endfunction : stat

  function automatic logic [5:0] osc(logic [3:0] c, logic p);
    casez (c)
      4'b1???: return {2'h0, (c == 4'hE && p) ? 4'h0 : 4'hF - c};
      4'b01??: return {2'h1, 4'h7 - c};
      4'h3: return {2'h0, 4'h9};
      4'h2: return {2'h1, 4'h4};
      default: return {2'h2, 4'h0};
    endcase
  endfunction : osc

  initial forever #4 pclk = ~pclk;

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  end

  always @(posedge pclk)
    if (presetn === 1'b1 && pready === 1'b1)
    begin
      e = exp_q.pop_front();
      chk("prdata", prdata, e[31:0]);
      chk("pslverr", pslverr, e[32]);
    end

  // ==========================================================================
  // Main sequence.
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OSS_ADDR_CONTROL, 0, 33'h38);
    apb(0, OSS_ADDR_TUNING, 0, 33'h0);
    for (i = 0; i < 6; i++)
    begin
      rdy <= 7'($random(seed));
      sec_en <= i[0];
      apb(1, OSS_ADDR_STATUS, 32'hFF, 33'h0);
      repeat (3) @(posedge pclk);
      apb(0, OSS_ADDR_STATUS, 0, {25'h0, stat(1'b0)});
    end
    for (i = 0; i < 32; i++)
    begin
      r = $random(seed);
      force_pll <= r[8];
      apb(1, OSS_ADDR_CONTROL, {r[31:8], i[4], i[3:0], r[2], 1'b1, r[0]}, 33'h0);
      apb(0, OSS_ADDR_CONTROL, 0, {25'h0, i[4], i[3:0], 1'b0, 1'b1, r[0]});
      chk("pll_enable", pll_enable, r[8] | i[4]);
      chk("osc", {internal_osc, div}, osc(i[3:0], i[4]));
      chk("clk_source", clk_source, 2'h0);
    end
    for (i = 0; i < 4; i++)
    begin
      r = $random(seed);
      apb(1, OSS_ADDR_TUNING, {r[31:6], tv[i]}, 33'h0);
      apb(0, OSS_ADDR_TUNING, 0, {27'h0, tv[i]});
      chk("freq_trim", freq_trim, tv[i]);
    end
    apb(0, 12'h010, 0, {1'b1, 32'h0});
    apb(1, 12'h010, 32'hFFFFFFFF, {1'b1, 32'h0});
    cfg_src <= OSS_CFG_XT;
    apb(1, OSS_ADDR_CONTROL, 32'h38, 33'h0);
    repeat (2 * OSTN - 2)
    begin
      @(posedge pclk);
      tgl <= ~tgl;
    end
    repeat (6) @(posedge pclk);
    chk("ost early", startup_timer, 1'b0);
    repeat (4)
    begin
      @(posedge pclk);
      tgl <= ~tgl;
    end
    repeat (6) @(posedge pclk);
    chk("ost done", startup_timer, 1'b1);
    chk("clk_source", clk_source, 2'h2);
    apb(0, OSS_ADDR_STATUS, 0, {25'h0, stat(1'b1)});
    mon_en <= 1'b1;
    fail_raw <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("fail flag", fail_flag, 1'b1);
    chk("clk_source", clk_source, 2'h0);
    fail_raw <= 1'b0;
    apb(0, OSS_ADDR_FAIL, 0, 33'h1);
    apb(1, OSS_ADDR_FAIL, 32'h3, 33'h0);
    apb(0, OSS_ADDR_FAIL, 0, 33'h2);
    apb(1, OSS_ADDR_CONTROL, 32'h39, 33'h0);
    repeat (3) @(posedge pclk);
    chk("clk_source", clk_source, 2'h1);
    cfg_src <= 3'h5;
    apb(1, OSS_ADDR_CONTROL, 32'h38, 33'h0);
    repeat (3) @(posedge pclk);
    chk("clk_source", clk_source, 2'h2);
    chk("ost ext", startup_timer, 1'b1);
    give_verdict;
  end
endmodule : tb_oss_top
